// File: include/fifo_flag_pkg.sv
// Shared constants for the dual-clock FIFO flag logic.
// Assumes one system clock that samples the write and read clock pins.
// Operation
// - Master reset with pass select low chooses standard mode: empty and full flags.
// - Master reset with pass select high chooses fall-through mode: ready flags.
// - Fall-through: first word reaches outputs after three read clock edges, no enable.
// - A word is stored only on a write clock edge while write enable is low.
// - Fall-through: output-ready drops low once the first word is on the outputs.
// - Fall-through: almost-empty goes high once n plus two words are held.
// - Fall-through, depth 1024: half-full goes low at the 514th word.
// - Fall-through, depth 1024: almost-full goes low after 1025 minus m writes.
// - Fall-through: input-ready goes high and blocks writes at depth plus one words.
// - Fall-through: first read from full lowers input-ready; later reads raise others.
// - Fall-through: almost-empty goes low when n plus one words remain.
// - Fall-through: output-ready goes high after last read; reads ignored when empty.
// - Fall-through: output-ready has three register stages, input-ready two.
// - Standard: empty flag goes high after the first write into an empty memory.
// - Standard: almost-empty goes high once n plus one words are held.
// - Standard, depth 1024: half-full goes low after the 513rd word.
// - Standard, depth 1024: almost-full goes low after 1024 minus m writes.
// - Standard: full flag goes low and blocks writes at depth words.
// - Standard: first read from full raises full flag; later reads raise others.
// - Standard: almost-empty goes low when exactly n words remain.
// - Standard: empty and full flags come from register stages.
// - One of eight default offsets, picked by select inputs, is latched at master reset.
package fifo_flag_pkg;
  localparam int DEPTH_DEF = 1024;
  localparam int WIDTH_DEF = 36;
  // Extra word held by the output register in fall-through mode
  localparam int FT_EXTRA = 1;
  // Fall-through first word: two qualifying stages, loaded on the third edge
  localparam int FT_PRE_STAGES = 2;
  localparam int IR_STAGES = 2;
  localparam int OFFSET_SEL_W = 3;
  localparam logic [OFFSET_SEL_W-1:0] OFFSET_SEL_RST = 3'h0;
  // Indexed by {load mode, select1, select0}
  localparam int OFFSET_TABLE [8] = '{127, 255, 511, 63, 31, 7, 15, 3};
  typedef enum logic {PH_RESET = 1'b0, PH_RUN = 1'b1} phase_t;
endpackage

// File: logic/dual_clock_fifo_flag_modes.sv
// FIFO with standard and fall-through flag modes, written and read through clock pins.
// Assumes clk runs well above both pin clocks; pins settle two clk cycles before an edge.
module dual_clock_fifo_flag_modes #(
  parameter int WIDTH = fifo_flag_pkg::WIDTH_DEF,
  parameter int DEPTH = fifo_flag_pkg::DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_reset_n,
  input wire logic first_word_pass_select,
  input wire logic [fifo_flag_pkg::OFFSET_SEL_W-1:0] offset_sel,
  input wire logic write_clk,
  input wire logic write_en_n,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic read_clk,
  input wire logic read_en_n,
  output logic [WIDTH-1:0] data_out_bus,
  output logic fall_through_mode,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic output_ready_n,
  output logic input_ready_n,
  output logic half_full_flag_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 2;
  localparam int SW = fifo_flag_pkg::OFFSET_SEL_W;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2 + 1);
  localparam logic [CW-1:0] FT_FULL_C = CW'(DEPTH + fifo_flag_pkg::FT_EXTRA);

  if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_params
    $error("DEPTH must be a power of two of at least 8, WIDTH at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] clk_level;
  logic [2:0] clk_rise;
  logic [WIDTH+SW+2:0] ctl_level;
  logic wr_edge;
  logic rd_edge;
  logic mr_level_n;
  logic wen_n_s;
  logic ren_n_s;
  logic sel_s;
  logic [SW-1:0] offset_sel_s;
  logic [WIDTH-1:0] data_in_s;

  pin_sync #(.W(3)) u_clk_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({master_reset_n, read_clk, write_clk}),
    .level(clk_level),
    .rise(clk_rise)
  );

  pin_sync #(.W(WIDTH + SW + 3)) u_ctl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({data_in, offset_sel, first_word_pass_select, read_en_n, write_en_n}),
    .level(ctl_level),
    .rise()
  );

  assign wr_edge = clk_rise[0];
  assign rd_edge = clk_rise[1];
  assign mr_level_n = clk_level[2];
  assign wen_n_s = ctl_level[0];
  assign ren_n_s = ctl_level[1];
  assign sel_s = ctl_level[2];
  assign offset_sel_s = ctl_level[SW+2:3];
  assign data_in_s = ctl_level[WIDTH+SW+2:SW+3];

  ////////////////////////////////////////////////////////////////////////////////
  // Master reset: mode and offset capture

  fifo_flag_pkg::phase_t phase_q;
  logic fall_through_mode_q;
  logic [CW-1:0] offset_q;
  logic mr_active;

  assign mr_active = !mr_level_n;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_q <= fifo_flag_pkg::PH_RESET;
      fall_through_mode_q <= 1'b0;
      offset_q <= CW'(fifo_flag_pkg::OFFSET_TABLE[fifo_flag_pkg::OFFSET_SEL_RST]);
    end
    else if (mr_active)
    begin
      phase_q <= fifo_flag_pkg::PH_RESET;
      fall_through_mode_q <= sel_s;
      offset_q <= CW'(fifo_flag_pkg::OFFSET_TABLE[offset_sel_s]);
    end
    else
    begin
      case (phase_q)
        fifo_flag_pkg::PH_RESET: phase_q <= fifo_flag_pkg::PH_RUN;
        fifo_flag_pkg::PH_RUN: phase_q <= fifo_flag_pkg::PH_RUN;
        default: phase_q <= fifo_flag_pkg::PH_RESET;
      endcase
    end
  end

  assign fall_through_mode = fall_through_mode_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pointers, storage and output register

  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] mem_count_q;
  localparam int FT_PRE_W = fifo_flag_pkg::FT_PRE_STAGES;
  logic [FT_PRE_W-1:0] pre_q;
  logic [WIDTH-1:0] rd_data;
  logic running;
  logic mem_empty;
  logic wr_take;
  logic rd_req;
  logic out_valid;
  logic pop;
  logic drop;

  assign running = phase_q == fifo_flag_pkg::PH_RUN && !mr_active;
  assign mem_empty = mem_count_q == '0;
  assign out_valid = !output_ready_n;
  assign rd_req = rd_edge && !ren_n_s;
  // Stored only on a write edge with enable low and room left
  assign wr_take = running && wr_edge && !wen_n_s && mem_count_q < DEPTH_C;
  // Standard: every word needs a request; fall-through: third-edge prefetch or a read
  assign pop = running && !mem_empty && (fall_through_mode_q ?
    (rd_req && out_valid) || (rd_edge && !out_valid && pre_q[FT_PRE_W-1]) :
    rd_req);
  assign drop = running && fall_through_mode_q && rd_req && out_valid && mem_empty;

  word_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_ram (
    .clk(clk),
    .wr_en(wr_take),
    .wr_addr(wr_ptr_q),
    .wr_data(data_in_s),
    .rd_addr(rd_ptr_q),
    .rd_data(rd_data)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n || !running)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      mem_count_q <= '0;
    end
    else
    begin
      if (wr_take)
      begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      mem_count_q <= mem_count_q + CW'(wr_take) - CW'(pop);
    end
  end

  // The two qualifying stages plus the output-ready register make three stages
  always_ff @(posedge clk)
  begin
    if (!rst_n || !running)
    begin
      pre_q <= '0;
    end
    else if (rd_edge)
    begin
      pre_q <= {pre_q[FT_PRE_W-2:0] & {(FT_PRE_W-1){!mem_empty}}, !mem_empty};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !running)
    begin
      data_out_bus <= '0;
      output_ready_n <= 1'b1;
    end
    else if (pop)
    begin
      data_out_bus <= rd_data;
      output_ready_n <= !fall_through_mode_q;
    end
    else if (drop)
    begin
      output_ready_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags, each from a register

  logic [CW-1:0] level;
  logic [CW-1:0] extra;
  logic ir_s1_q;

  assign extra = fall_through_mode_q ? CW'(fifo_flag_pkg::FT_EXTRA) : '0;
  assign level = mem_count_q + (fall_through_mode_q ? CW'(out_valid) : '0);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      empty_flag_n <= 1'b0;
      full_flag_n <= 1'b1;
    end
    else
    begin
      empty_flag_n <= fall_through_mode_q || level != '0;
      full_flag_n <= fall_through_mode_q || level != DEPTH_C;
    end
  end

  // Input-ready passes two stages; writes are refused earlier by the live count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ir_s1_q <= 1'b0;
      input_ready_n <= 1'b0;
    end
    else
    begin
      ir_s1_q <= fall_through_mode_q && level == FT_FULL_C;
      input_ready_n <= ir_s1_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      half_full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
    end
    else
    begin
      half_full_flag_n <= level < HALF_C + extra;
      almost_full_flag_n <= level < DEPTH_C - offset_q + extra;
      almost_empty_flag_n <= level >= offset_q + CW'(1) + extra;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_mode_std;
    mr_active && !sel_s |=> !fall_through_mode;
  endproperty
  a_mode_std: assert property (p_mode_std) else $error("standard mode not latched");

  property p_mode_ft;
    mr_active && sel_s |=> fall_through_mode;
  endproperty
  a_mode_ft: assert property (p_mode_ft) else $error("fall-through mode not latched");

  property p_first_word;
    running && fall_through_mode_q && rd_edge && !out_valid && pre_q[FT_PRE_W-1] && !mem_empty
      |=> !output_ready_n && data_out_bus == $past(rd_data);
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not presented");

  property p_no_write_when_full;
    running && mem_count_q == DEPTH_C |=> $stable(wr_ptr_q);
  endproperty
  a_no_write_when_full: assert property (p_no_write_when_full) else $error("write while full");

  property p_empty_read_ignored;
    running && mem_empty && !out_valid |=> $stable(data_out_bus) && $stable(rd_ptr_q);
  endproperty
  a_empty_read_ignored: assert property (p_empty_read_ignored) else $error("read while empty");

  property p_empty_flag;
    !fall_through_mode_q && level != '0 && !mr_active |=> empty_flag_n;
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag stuck low");

  property p_full_flag;
    !fall_through_mode_q && mem_count_q == DEPTH_C ##1 mem_count_q == DEPTH_C |=> !full_flag_n;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag not low");

  property p_ir_two_stage;
    fall_through_mode_q && level == FT_FULL_C ##1 fall_through_mode_q && level == FT_FULL_C |=> input_ready_n;
  endproperty
  a_ir_two_stage: assert property (p_ir_two_stage) else $error("input ready late");

  property p_almost_empty;
    !mr_active ##1 $stable(level) && $stable(offset_q) && $stable(fall_through_mode_q)
      |=> almost_empty_flag_n == ($past(level) > $past(offset_q) + $past(extra));
  endproperty
  a_almost_empty: assert property (p_almost_empty) else $error("almost-empty wrong");

  property p_half_full;
    $stable(level) && $stable(fall_through_mode_q)
      |=> half_full_flag_n == ($past(level) < HALF_C + $past(extra));
  endproperty
  a_half_full: assert property (p_half_full) else $error("half-full wrong");

  c_fill_full: cover property (running && !fall_through_mode_q && mem_count_q == DEPTH_C);
  c_ft_first: cover property (running && fall_through_mode_q && $fell(output_ready_n));
  c_ft_drain: cover property (running && fall_through_mode_q && $rose(output_ready_n));
endmodule

// File: logic/pin_sync.sv
// Three-flop synchroniser with agreement filter and rising-edge pulse.
// Assumes pins are asynchronous to clk; a change counts once stages two and three agree.
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level <= '0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= (level & ~agree) | (s3_q & agree);
    end
  end

  assign agree = ~(s2_q ^ s3_q);
  assign rise = agree & s3_q & ~level;
endmodule

// File: logic/word_ram.sv
// Word storage with one write port and one asynchronous read port.
// Assumes the caller keeps addresses in range and registers the read data.
module word_ram #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 1024
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset: contents are meaningless until written
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// File: sim/pin_partner.sv
// Writer and reader pin model that clocks words in and out through the pin clocks.
// Assumes pins change on the falling edge of clk and the pin clocks idle low between words.
module pin_partner #(
  parameter int WIDTH = 36
) (
  input wire logic clk,
  output logic write_clk,
  output logic write_en_n,
  output logic [WIDTH-1:0] data_in,
  output logic read_clk,
  output logic read_en_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    write_clk = 1'b0;
    write_en_n = 1'b1;
    data_in = '0;
    read_clk = 1'b0;
    read_en_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phases of three clk keep the three-flop filter happy; the tail lets flags settle
  task automatic write_word(input logic [WIDTH-1:0] v, input logic en);
    write_en_n <= !en;
    data_in <= v;
    repeat (3) @(negedge clk);
    write_clk <= 1'b1;
    repeat (3) @(negedge clk);
    write_clk <= 1'b0;
    repeat (3) @(negedge clk);
    write_en_n <= 1'b1;
    // A released bus must not keep showing the last word
    data_in <= ~v;
    // One idle edge so a following word never re-drives in the same step
    @(negedge clk);
  endtask

  task automatic read_word(input logic en);
    read_en_n <= !en;
    repeat (3) @(negedge clk);
    read_clk <= 1'b1;
    repeat (3) @(negedge clk);
    read_clk <= 1'b0;
    repeat (3) @(negedge clk);
    read_en_n <= 1'b1;
    @(negedge clk);
  endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the two-mode FIFO flag logic, expected levels from a word count.
// Assumes the pin partner drives the pin clocks and the design runs at its default depth.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = fifo_flag_pkg::WIDTH_DEF;
  localparam int D = fifo_flag_pkg::DEPTH_DEF;

  logic clk, rst_n, master_reset_n, first_word_pass_select;
  logic [fifo_flag_pkg::OFFSET_SEL_W-1:0] offset_sel;
  logic write_clk, write_en_n, read_clk, read_en_n;
  logic [W-1:0] data_in, data_out_bus;
  logic fall_through_mode, empty_flag_n, full_flag_n, output_ready_n, input_ready_n;
  logic half_full_flag_n, almost_full_flag_n, almost_empty_flag_n;
  logic [6:0] flg;
  int err_count, samples_checked, cycles, lvl, n_off;
  logic ft;
  integer seed = 32'h57b4;
  logic [W-1:0] q[$];

  assign flg = {empty_flag_n, full_flag_n, output_ready_n, input_ready_n,
                half_full_flag_n, almost_full_flag_n, almost_empty_flag_n};

  dual_clock_fifo_flag_modes dut (.clk(clk), .rst_n(rst_n), .master_reset_n(master_reset_n),
    .first_word_pass_select(first_word_pass_select), .offset_sel(offset_sel),
    .write_clk(write_clk), .write_en_n(write_en_n), .data_in(data_in),
    .read_clk(read_clk), .read_en_n(read_en_n), .data_out_bus(data_out_bus),
    .fall_through_mode(fall_through_mode), .empty_flag_n(empty_flag_n),
    .full_flag_n(full_flag_n), .output_ready_n(output_ready_n),
    .input_ready_n(input_ready_n), .half_full_flag_n(half_full_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n));

  pin_partner #(.WIDTH(W)) p (.clk(clk), .write_clk(write_clk), .write_en_n(write_en_n),
    .data_in(data_in), .read_clk(read_clk), .read_en_n(read_en_n));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling sits well above the roughly 55k cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Fall-through counts the output register as one more word
  function automatic logic [6:0] exp_flags(input int l);
    if (!ft)
      return {l != 0, l != D, 1'b1, 1'b0, !(l >= D / 2 + 1), !(l >= D - n_off), l > n_off};
    return {1'b1, 1'b1, l == 0, l == D + 1, !(l >= D / 2 + 2), !(l >= D - n_off + 1),
            l > n_off + 1};
  endfunction

  task automatic check_flags();
    if (!ft)
      check("flags", flg, exp_flags(lvl));
    else
      check("flags", flg, exp_flags(lvl));
    check("mode", fall_through_mode, ft);
  endtask

  task automatic mreset(input logic f, input logic [2:0] sel);
    master_reset_n <= 1'b0;
    first_word_pass_select <= f;
    offset_sel <= sel;
    repeat (8) @(negedge clk);
    master_reset_n <= 1'b1;
    repeat (6) @(negedge clk);
    ft = f;
    n_off = fifo_flag_pkg::OFFSET_TABLE[sel];
    lvl = 0;
    q.delete();
    check_flags();
  endtask

  task automatic wr(input logic en);
    logic [W-1:0] v;
    v = W'({$random(seed), $random(seed)});
    p.write_word(v, en);
    if (en && lvl < (ft ? D + 1 : D))
    begin
      q.push_back(v);
      lvl++;
      if (ft && lvl == 1)
      begin
        p.read_word(1'b0);
        p.read_word(1'b0);
        check("ready early", output_ready_n, 1'b1);
        p.read_word(1'b0);
        check("first word", data_out_bus, q[0]);
      end
    end
    check_flags();
  endtask

  task automatic rd(input logic en);
    logic [W-1:0] held;
    held = data_out_bus;
    p.read_word(en);
    if (en && lvl > 0)
    begin
      if (!ft)
        check("read data", data_out_bus, q[0]);
      void'(q.pop_front());
      lvl--;
      if (ft && lvl > 0)
        check("next word", data_out_bus, q[0]);
    end
    else
      check("data held", data_out_bus, held);
    check_flags();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    master_reset_n = 1'b0;
    first_word_pass_select = 1'b0;
    offset_sel = 3'h0;
    repeat (6) @(negedge clk);
    rst_n <= 1'b1;
    mreset(1'b0, 3'($random(seed)));
    repeat (D + 1) wr(1'b1);
    rd(1'b1);
    check("full released", full_flag_n, 1'b1);
    repeat (D) rd(1'b1);
    $display("test standard fill and drain done");
    mreset(1'b0, 3'($random(seed)));
    repeat (300)
    begin
      if ($random(seed) & 1)
        wr(($random(seed) & 3) != 0);
      else
        rd(($random(seed) & 3) != 0);
    end
    $display("test standard random mix done");
    mreset(1'b1, 3'($random(seed)));
    repeat (D + 2) wr(1'b1);
    rd(1'b1);
    check("input ready back", input_ready_n, 1'b0);
    repeat (D + 1) rd(1'b1);
    $display("test fall-through fill and drain done");
    for (int i = 0; i < 8; i++)
    begin
      mreset(1'b0, 3'(i));
      repeat (n_off + 2) wr(1'b1);
      repeat (2) rd(1'b1);
    end
    $display("test offset codes done");
    end_of_test();
  end
endmodule
